// file: ssd_pkg.sv
/*
  Shared constants of the subtract / nibble-exchange / direction-load
  execution block: instruction encodings, field positions, local register
  offsets, flag layout and reset values.
  Assumes a 14-bit instruction word and an 8-bit data path.
*/
`default_nettype none

package ssd_pkg;

  // Instruction word and field geometry
  localparam int INSTR_W = 14;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int NIBBLE_W = 4;
  localparam int DEST_BIT = 7;
  localparam int SEL_W = 3;

  // Opcode recognition: (instr & mask) == pattern
  localparam logic [13:0] OPC_FILE_MASK = 14'h3F00;
  localparam logic [13:0] OPC_SUB_ACC_FROM_FILE = 14'h0200;
  localparam logic [13:0] OPC_NIBBLE_EXCHANGE = 14'h0E00;
  localparam logic [13:0] OPC_DIRLOAD_MASK = 14'h3FF8;
  localparam logic [13:0] OPC_PORT_DIR_LOAD = 14'h0060;

  // Legal direction-load selectors
  localparam logic [2:0] DIR_SEL_FIRST = 3'h5;
  localparam logic [2:0] DIR_SEL_MID = 3'h6;
  localparam logic [2:0] DIR_SEL_LAST = 3'h7;

  // Destination bit values
  localparam logic DEST_ACC = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  // Local register offsets on the register port
  localparam logic [6:0] OFS_ACC = 7'h00;
  localparam logic [6:0] OFS_FLAGS = 7'h01;
  localparam logic [6:0] OFS_PORT_DIR5 = 7'h05;
  localparam logic [6:0] OFS_PORT_DIR6 = 7'h06;
  localparam logic [6:0] OFS_PORT_DIR7 = 7'h07;

  // Flag register layout
  localparam int FLAG_CARRY_BIT = 0;
  localparam int FLAG_DIGIT_CARRY_BIT = 1;
  localparam int FLAG_ZERO_BIT = 2;

  // Reset values; direction registers reset to all inputs
  localparam logic [7:0] RST_ACC = 8'h00;
  localparam logic [7:0] RST_PORT_DIR = 8'hFF;
  localparam logic RST_FLAG = 1'b0;
  localparam logic [7:0] RDATA_IDLE = 8'h00;

endpackage : ssd_pkg

`default_nettype wire

// file: ssd_sub_unit.sv
/*
  Two's complement subtractor: minuend minus subtrahend with carry
  (inverted borrow), digit carry out of the low nibble, and zero detect.
  Purely combinational; the caller registers the results.
*/
`timescale 1ns/1ns
`default_nettype none

module ssd_sub_unit #(
  parameter int WIDTH = 8,
  parameter int NIB = 4
) (
  input wire logic [WIDTH-1:0] minuend_i,
  input wire logic [WIDTH-1:0] subtrahend_i,
  output logic [WIDTH-1:0] diff_o,
  output logic carry_o,
  output logic digit_carry_o,
  output logic zero_o
);

  // Nibble carry is only meaningful when the nibble splits the word
  if (WIDTH < 2 * NIB || NIB < 1)
  begin : g_bad_width
    $error("ssd_sub_unit: WIDTH must hold at least two nibbles");
  end

  logic [WIDTH:0] full_sum;
  logic [NIB:0] low_sum;

  // Add the inverted subtrahend plus one so carry reads as no-borrow
  always_comb
  begin
    full_sum = {1'b0, minuend_i} + {1'b0, ~subtrahend_i} + {{WIDTH{1'b0}}, 1'b1};
    low_sum = {1'b0, minuend_i[NIB-1:0]} + {1'b0, ~subtrahend_i[NIB-1:0]} + {{NIB{1'b0}}, 1'b1};
    diff_o = full_sum[WIDTH-1:0];    // Wraps modulo two to the WIDTH
    carry_o = full_sum[WIDTH];
    digit_carry_o = low_sum[NIB];
    zero_o = (full_sum[WIDTH-1:0] == '0);
  end

endmodule // ssd_sub_unit

`default_nettype wire

// file: ssd_exec.sv
/*
  Execution unit for three single-word instructions of an 8-bit core:
  subtract accumulator from file register, nibble exchange of a file
  register, and the compatibility port direction load. It owns the
  accumulator, the carry / digit carry / zero flags and three port
  direction registers, and emits registered file write-backs.
  Assumes the decode stage presents the instruction together with the
  current content of the addressed file register in the same cycle, and
  that the register file applies file_we_o on the following edge.
*/
// Local design decisions: the placing of the registers and strobed register access.
// Behaviour
// - Subtract decodes dest bit and address; file minus accumulator
// - Dest zero writes accumulator, one writes file register
// - Subtract sets carry, digit carry, zero; carry inverted borrow
// - Zero difference sets carry and zero flag
// - Negative difference clears carry; result wraps modulo 256
// - Nibble exchange swaps file halves, flags untouched
// - Exchange result to accumulator or file by dest
// - Direction load copies accumulator to selector five-seven
// - Direction registers also reachable by plain register access
`timescale 1ns/1ns
`default_nettype none

module ssd_exec #(
  parameter int DATA_W = ssd_pkg::DATA_W,
  parameter int FADDR_W = ssd_pkg::FADDR_W
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // Instruction issue, one per cycle at most
  input wire logic instr_valid_i,
  input wire logic [ssd_pkg::INSTR_W-1:0] instr_i,
  input wire logic [DATA_W-1:0] file_rdata_i,
  // File register write-back
  output logic file_we_o,
  output logic [FADDR_W-1:0] file_waddr_o,
  output logic [DATA_W-1:0] file_wdata_o,
  // Architectural state
  output logic [DATA_W-1:0] acc_o,
  output logic carry_o,
  output logic digit_carry_o,
  output logic zero_o,
  output logic [DATA_W-1:0] port_dir5_o,
  output logic [DATA_W-1:0] port_dir6_o,
  output logic [DATA_W-1:0] port_dir7_o,
  // Completion and refusal pulses
  output logic exec_done_o,
  output logic instr_unknown_o,
  // Register port
  input wire logic [6:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [DATA_W-1:0] reg_rdata_o
);

  // The encodings and the wrap behaviour are fixed to this geometry
  if (DATA_W != ssd_pkg::DATA_W || FADDR_W != ssd_pkg::FADDR_W)
  begin : g_bad_geometry
    $error("ssd_exec: DATA_W must be 8 and FADDR_W must be 7");
  end

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  logic is_sub;
  logic is_swap;
  logic is_dirload;
  logic dest_bit;
  logic [FADDR_W-1:0] faddr;
  logic [ssd_pkg::SEL_W-1:0] dir_sel;
  logic dir_sel_ok;

  // Opcode match on masked patterns; selector outside 5..7 is not ours
  always_comb
  begin
    dest_bit = instr_i[ssd_pkg::DEST_BIT];
    faddr = instr_i[FADDR_W-1:0];
    dir_sel = instr_i[ssd_pkg::SEL_W-1:0];
    is_sub = instr_valid_i && ((instr_i & ssd_pkg::OPC_FILE_MASK) == ssd_pkg::OPC_SUB_ACC_FROM_FILE);
    is_swap = instr_valid_i && ((instr_i & ssd_pkg::OPC_FILE_MASK) == ssd_pkg::OPC_NIBBLE_EXCHANGE);
    dir_sel_ok = (dir_sel >= ssd_pkg::DIR_SEL_FIRST) && (dir_sel <= ssd_pkg::DIR_SEL_LAST);
    is_dirload = instr_valid_i && dir_sel_ok
                 && ((instr_i & ssd_pkg::OPC_DIRLOAD_MASK) == ssd_pkg::OPC_PORT_DIR_LOAD);
  end

  // ---------------------------------------------------------------
  // Arithmetic
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] acc_reg;
  logic [DATA_W-1:0] sub_diff;
  logic sub_carry;
  logic sub_dc;
  logic sub_zero;
  logic [DATA_W-1:0] swap_val;

  ssd_sub_unit #(
    .WIDTH(DATA_W),
    .NIB(ssd_pkg::NIBBLE_W)
  ) u_sub (
    .minuend_i(file_rdata_i),
    .subtrahend_i(acc_reg),
    .diff_o(sub_diff),
    .carry_o(sub_carry),
    .digit_carry_o(sub_dc),
    .zero_o(sub_zero)
  );

  // low nibble moves up, high nibble moves down
  assign swap_val = {file_rdata_i[ssd_pkg::NIBBLE_W-1:0], file_rdata_i[DATA_W-1:ssd_pkg::NIBBLE_W]};

  // ---------------------------------------------------------------
  // Accumulator, flags and file write-back
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] acc_next;
  logic carry_reg;
  logic carry_next;
  logic dc_reg;
  logic dc_next;
  logic zero_reg;
  logic zero_next;
  logic file_we_reg;
  logic file_we_next;
  logic [FADDR_W-1:0] file_waddr_reg;
  logic [FADDR_W-1:0] file_waddr_next;
  logic [DATA_W-1:0] file_wdata_reg;
  logic [DATA_W-1:0] file_wdata_next;
  logic done_reg;
  logic done_next;
  logic unknown_reg;
  logic unknown_next;
  logic [DATA_W-1:0] result;
  logic result_valid;

  // Instruction writes beat a register-port write in the same cycle,
  // since the core must not lose a committed result.
  always_comb
  begin
    acc_next = acc_reg;
    carry_next = carry_reg;
    dc_next = dc_reg;
    zero_next = zero_reg;
    file_we_next = 1'b0;
    file_waddr_next = file_waddr_reg;
    file_wdata_next = file_wdata_reg;
    result = is_sub ? sub_diff : swap_val;
    result_valid = is_sub || is_swap;

    // Software access to accumulator and flags
    if (reg_we_i && reg_addr_i == ssd_pkg::OFS_ACC)
    begin
      acc_next = reg_wdata_i;
    end
    if (reg_we_i && reg_addr_i == ssd_pkg::OFS_FLAGS)
    begin
      carry_next = reg_wdata_i[ssd_pkg::FLAG_CARRY_BIT];
      dc_next = reg_wdata_i[ssd_pkg::FLAG_DIGIT_CARRY_BIT];
      zero_next = reg_wdata_i[ssd_pkg::FLAG_ZERO_BIT];
    end

    if (result_valid)
    begin
      if (dest_bit == ssd_pkg::DEST_ACC)
      begin
        acc_next = result;
      end
      else
      begin
        file_we_next = 1'b1;
        file_waddr_next = faddr;
        file_wdata_next = result;
      end
    end

    // carry as inverted borrow plus digit carry
    // zero result sets zero and carry
    if (is_sub)
    begin
      carry_next = sub_carry;
      dc_next = sub_dc;
      zero_next = sub_zero;
    end

    // everything commits at this cycle's end
    done_next = result_valid || is_dirload;
    unknown_next = instr_valid_i && !(result_valid || is_dirload);
  end

  // Registered commit of accumulator, flags and write-back
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      acc_reg <= ssd_pkg::RST_ACC;
      carry_reg <= ssd_pkg::RST_FLAG;
      dc_reg <= ssd_pkg::RST_FLAG;
      zero_reg <= ssd_pkg::RST_FLAG;
      file_we_reg <= 1'b0;
      file_waddr_reg <= '0;
      file_wdata_reg <= '0;
      done_reg <= 1'b0;
      unknown_reg <= 1'b0;
    end
    else
    begin
      acc_reg <= acc_next;
      carry_reg <= carry_next;
      dc_reg <= dc_next;
      zero_reg <= zero_next;
      file_we_reg <= file_we_next;
      file_waddr_reg <= file_waddr_next;
      file_wdata_reg <= file_wdata_next;
      done_reg <= done_next;
      unknown_reg <= unknown_next;
    end
  end

  // ---------------------------------------------------------------
  // Port direction registers
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] dir5_reg;
  logic [DATA_W-1:0] dir5_next;
  logic [DATA_W-1:0] dir6_reg;
  logic [DATA_W-1:0] dir6_next;
  logic [DATA_W-1:0] dir7_reg;
  logic [DATA_W-1:0] dir7_next;

  // Flags are never touched here; the instruction again wins a collision
  always_comb
  begin
    dir5_next = dir5_reg;
    dir6_next = dir6_reg;
    dir7_next = dir7_reg;
    if (reg_we_i)
    begin
      unique case (reg_addr_i)
        ssd_pkg::OFS_PORT_DIR5: dir5_next = reg_wdata_i;
        ssd_pkg::OFS_PORT_DIR6: dir6_next = reg_wdata_i;
        ssd_pkg::OFS_PORT_DIR7: dir7_next = reg_wdata_i;
        default: ;
      endcase
    end
    if (is_dirload)
    begin
      unique case (dir_sel)
        ssd_pkg::DIR_SEL_FIRST: dir5_next = acc_reg;
        ssd_pkg::DIR_SEL_MID: dir6_next = acc_reg;
        ssd_pkg::DIR_SEL_LAST: dir7_next = acc_reg;
        default: ;
      endcase
    end
  end

  // Direction registers reset to all-input
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      dir5_reg <= ssd_pkg::RST_PORT_DIR;
      dir6_reg <= ssd_pkg::RST_PORT_DIR;
      dir7_reg <= ssd_pkg::RST_PORT_DIR;
    end
    else
    begin
      dir5_reg <= dir5_next;
      dir6_reg <= dir6_next;
      dir7_reg <= dir7_next;
    end
  end

  // ---------------------------------------------------------------
  // Register port read path
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic [DATA_W-1:0] flags_word;

  // Read data stands for one cycle only; unmapped offsets read zero.
  // Reads see the value before any write in the same cycle.
  always_comb
  begin
    flags_word = '0;
    flags_word[ssd_pkg::FLAG_CARRY_BIT] = carry_reg;
    flags_word[ssd_pkg::FLAG_DIGIT_CARRY_BIT] = dc_reg;
    flags_word[ssd_pkg::FLAG_ZERO_BIT] = zero_reg;
    rdata_next = ssd_pkg::RDATA_IDLE;
    if (reg_re_i)
    begin
      unique case (reg_addr_i)
        ssd_pkg::OFS_ACC: rdata_next = acc_reg;
        ssd_pkg::OFS_FLAGS: rdata_next = flags_word;
        ssd_pkg::OFS_PORT_DIR5: rdata_next = dir5_reg;
        ssd_pkg::OFS_PORT_DIR6: rdata_next = dir6_reg;
        ssd_pkg::OFS_PORT_DIR7: rdata_next = dir7_reg;
        default: rdata_next = ssd_pkg::RDATA_IDLE;
      endcase
    end
  end

  // Read data register
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rdata_reg <= ssd_pkg::RDATA_IDLE;
    end
    else
    begin
      rdata_reg <= rdata_next;
    end
  end

  // Every output straight from a flip-flop
  assign file_we_o = file_we_reg;
  assign file_waddr_o = file_waddr_reg;
  assign file_wdata_o = file_wdata_reg;
  assign acc_o = acc_reg;
  assign carry_o = carry_reg;
  assign digit_carry_o = dc_reg;
  assign zero_o = zero_reg;
  assign port_dir5_o = dir5_reg;
  assign port_dir6_o = dir6_reg;
  assign port_dir7_o = dir7_reg;
  assign exec_done_o = done_reg;
  assign instr_unknown_o = unknown_reg;
  assign reg_rdata_o = rdata_reg;

endmodule // ssd_exec

`default_nettype wire

// file: ssd_exec_asserts.sv
/*
  Port checker for ssd_exec: result, flag and timing relations.
  Assumes default parameters; bound to the design at the foot of this file.
*/
`timescale 1ns/1ns
`default_nettype none

module ssd_exec_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic instr_valid_i,
  input wire logic [13:0] instr_i,
  input wire logic [7:0] file_rdata_i,
  input wire logic file_we_o,
  input wire logic [6:0] file_waddr_o,
  input wire logic [7:0] file_wdata_o,
  input wire logic [7:0] acc_o,
  input wire logic carry_o,
  input wire logic digit_carry_o,
  input wire logic zero_o,
  input wire logic [7:0] port_dir5_o,
  input wire logic exec_done_o,
  input wire logic instr_unknown_o,
  input wire logic [6:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  input wire logic [7:0] reg_rdata_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Decode and operands at the issue edge; results must land one edge later
  logic sub, swp, dir, bad, ok, fwr, dcn;
  logic [6:0] fa;
  logic [7:0] diff, sw;
  assign sub = instr_valid_i && instr_i[13:8] == 6'h02;
  assign swp = instr_valid_i && instr_i[13:8] == 6'h0E;
  assign dir = instr_valid_i && instr_i[13:3] == 11'h00C && instr_i[2:0] >= 3'h5;
  assign bad = instr_valid_i && instr_i[13:3] == 11'h00C && instr_i[2:0] < 3'h5;
  assign ok = sub || swp || dir;
  assign fwr = reg_we_i && reg_addr_i == 7'h01;
  assign fa = instr_i[6:0];
  assign diff = file_rdata_i - acc_o;
  assign sw = {file_rdata_i[3:0], file_rdata_i[7:4]};
  assign dcn = file_rdata_i[3:0] >= acc_o[3:0];

  a_sub_to_acc: assert property (sub && !instr_i[7] |=> acc_o == $past(diff) && !file_we_o)
    else $error("subtract result not in accumulator");
  a_sub_to_file: assert property (
    sub && instr_i[7] |=> file_we_o && file_wdata_o == $past(diff) && file_waddr_o == $past(fa))
    else $error("subtract result not written back");
  a_sub_carry: assert property (sub |=> carry_o == ($past(file_rdata_i) >= $past(acc_o)))
    else $error("subtract carry wrong");
  a_sub_zero: assert property (sub |=> zero_o == ($past(diff) == 8'h00))
    else $error("subtract zero flag wrong");
  a_sub_dcarry: assert property (sub |=> digit_carry_o == $past(dcn))
    else $error("subtract digit carry wrong");
  a_swap_acc: assert property (swp && !instr_i[7] |=> acc_o == $past(sw) && !file_we_o)
    else $error("exchange result not in accumulator");
  a_swap_file: assert property (
    swp && instr_i[7] |=> file_we_o && file_wdata_o == $past(sw) && file_waddr_o == $past(fa))
    else $error("exchange result not written back");
  a_swap_flags: assert property (swp && !fwr |=> $stable({carry_o, digit_carry_o, zero_o}))
    else $error("exchange changed flags");
  a_dir_load: assert property (dir && instr_i[2:0] == 3'h5 |=> port_dir5_o == $past(acc_o))
    else $error("direction load wrong");
  a_dir_refuse: assert property (
    bad && !reg_we_i |=> instr_unknown_o && !exec_done_o && $stable(port_dir5_o))
    else $error("bad selector not refused");
  a_dir_regwr: assert property (reg_we_i && reg_addr_i == 7'h05 && !dir |=> port_dir5_o == $past(reg_wdata_i))
    else $error("direction register write lost");
  a_dir_regrd: assert property (reg_re_i && reg_addr_i == 7'h05 |=> reg_rdata_o == $past(port_dir5_o))
    else $error("direction register read wrong");
  a_one_cycle: assert property (ok |=> exec_done_o && !instr_unknown_o)
    else $error("instruction not done in one cycle");
  a_rdata_idle: assert property (!reg_re_i |=> reg_rdata_o == 8'h00)
    else $error("read data not idle outside a read");
endmodule // ssd_exec_asserts

bind ssd_exec ssd_exec_asserts ssd_exec_asserts_i (
  .clk_i, .rst_i, .instr_valid_i, .instr_i, .file_rdata_i, .file_we_o, .file_waddr_o, .file_wdata_o, .acc_o,
  .carry_o, .digit_carry_o, .zero_o, .port_dir5_o, .exec_done_o, .instr_unknown_o, .reg_addr_i, .reg_wdata_i,
  .reg_we_i, .reg_re_i, .reg_rdata_o);

`default_nettype wire

// file: ssd_exec_tb.sv
/*
  Self-checking bench for ssd_exec: drivers note expected results in a queue,
  a monitor compares them as they appear.
  Assumes ssd_pkg, the design and its checker are compiled before it.
*/
`timescale 1ns/1ns
`default_nettype none

module ssd_exec_tb;
  logic clk_i, rst_i, instr_valid_i, reg_we_i, reg_re_i, rd_q;
  logic [13:0] instr_i;
  logic [7:0] file_rdata_i, reg_wdata_i, acc_o, file_wdata_o, reg_rdata_o;
  logic [7:0] port_dir5_o, port_dir6_o, port_dir7_o;
  logic [6:0] reg_addr_i, file_waddr_o, m_wa;
  logic file_we_o, carry_o, digit_carry_o, zero_o, exec_done_o, instr_unknown_o;
  // Model: index 0 accumulator, 1 flags, 5..7 direction registers
  logic [7:0] m_reg [0:7];
  logic [7:0] m_wd;
  // Instruction notes carry three zero pad bits; read notes carry the direction outputs
  logic [31:0] exp_q [$];
  logic [6:0] ra [6] = '{7'h00, 7'h01, 7'h05, 7'h06, 7'h07, 7'h2A};
  int miscompares = 0;
  int num_checks = 0;
  int seed = 1;

  ssd_exec ssd_exec_i (.clk_i, .rst_i, .instr_valid_i, .instr_i, .file_rdata_i, .file_we_o, .file_waddr_o,
    .file_wdata_o, .acc_o, .carry_o, .digit_carry_o, .zero_o, .port_dir5_o, .port_dir6_o, .port_dir7_o,
    .exec_done_o, .instr_unknown_o, .reg_addr_i, .reg_wdata_i, .reg_we_i, .reg_re_i, .reg_rdata_o);

  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // Issue one word; strobes stay up so issues can run back to back
  task automatic exe(input logic [13:0] w, input logic [7:0] f);
    logic [7:0] a, r;
    logic ok, fl;
    a = m_reg[0];
    ok = 1'b1;
    r = {f[3:0], f[7:4]};
    if (w[13:8] == 6'h02)
    begin
      r = f - a;
      m_reg[1] = {5'h00, r == 8'h00, f[3:0] >= a[3:0], f >= a};
    end
    else if (w[13:3] == 11'h00C && w[2:0] >= 3'h5)
      m_reg[w[2:0]] = a;
    else if (w[13:8] != 6'h0E)
      ok = 1'b0;
    fl = ok && w[13:3] != 11'h00C;
    if (fl && w[7])
    begin
      m_wa = w[6:0];
      m_wd = r;
    end
    else if (fl)
      m_reg[0] = r;
    exp_q.push_back({3'h0, !ok, ok, fl && w[7], m_wa, m_wd, m_reg[0], m_reg[1][2:0]});
    instr_valid_i <= 1'b1;
    instr_i <= w;
    file_rdata_i <= f;
    reg_we_i <= 1'b0;
    reg_re_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // Register port write; unmapped places are ignored
  task automatic wr(input logic [6:0] ad, input logic [7:0] v);
    if (ad == 7'h01)
      m_reg[1] = {5'h00, v[2:0]};
    else if (ad inside {7'h00, 7'h05, 7'h06, 7'h07})
      m_reg[ad[2:0]] = v;
    instr_valid_i <= 1'b0;
    reg_we_i <= 1'b1;
    reg_re_i <= 1'b0;
    reg_addr_i <= ad;
    reg_wdata_i <= v;
    @(posedge clk_i);
  endtask

  // Register port read; data is checked the cycle after
  task automatic rd(input logic [6:0] ad);
    exp_q.push_back({m_reg[7], m_reg[6], m_reg[5],
      ((ad inside {7'h00, 7'h01, 7'h05, 7'h06, 7'h07}) ? m_reg[ad[2:0]] : 8'h00)});
    instr_valid_i <= 1'b0;
    reg_we_i <= 1'b0;
    reg_re_i <= 1'b1;
    reg_addr_i <= ad;
    @(posedge clk_i);
  endtask

  task automatic chk(input logic [31:0] o);
    logic [31:0] e;
    num_checks++;
    e = exp_q.size() > 0 ? exp_q.pop_front() : 'x;
    if (o !== e)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, o, e);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Sample at the falling edge, where registered outputs have settled
  always @(posedge clk_i)
    rd_q <= reg_re_i;
  always @(negedge clk_i)
  begin
    if (exec_done_o === 1'b1 || instr_unknown_o === 1'b1)
      chk({3'h0, instr_unknown_o, exec_done_o, file_we_o, file_waddr_o, file_wdata_o,
        acc_o, zero_o, digit_carry_o, carry_o});
    // Direction outputs are compared with the model on every read cycle
    if (rd_q === 1'b1)
      chk({port_dir7_o, port_dir6_o, port_dir5_o, reg_rdata_o});
  end

  // Guard against a hang anywhere in the run
  initial
  begin
    repeat (5000) @(posedge clk_i);
    miscompares++;
    end_of_test;
  end

  initial
  begin
    logic [31:0] r;
    rst_i = 1'b1;
    instr_valid_i = 1'b0;
    instr_i = 14'h0000;
    file_rdata_i = 8'h00;
    reg_we_i = 1'b0;
    reg_re_i = 1'b0;
    reg_addr_i = 7'h00;
    reg_wdata_i = 8'h00;
    m_reg = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF};
    m_wa = 7'h00;
    m_wd = 8'h00;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    foreach (ra[i]) rd(ra[i]);
    wr(7'h00, 8'h02);
    for (int i = 0; i < 3; i++) exe({6'h02, 1'b1, 7'h21}, 8'(3 - i));
    exe({6'h02, 1'b0, 7'h10}, 8'h01);
    exe({6'h02, 1'b0, 7'h10}, 8'h10);
    wr(7'h01, 8'h07);
    exe({6'h0E, 1'b0, 7'h05}, 8'hA5);
    exe({6'h0E, 1'b1, 7'h7F}, 8'h3C);
    wr(7'h00, 8'h96);
    for (int s = 0; s < 8; s++) exe({11'h00C, 3'(s)}, 8'h00);
    foreach (ra[i]) rd(ra[i]);
    // plain port access and an unmapped write
    wr(7'h05, 8'h3A);
    wr(7'h2A, 8'h55);
    rd(7'h05);
    rd(7'h2A);
    repeat (120)
    begin
      r = $random(seed);
      case (r[10:8])
        3'd0, 3'd1: exe({6'h02, r[7:0]}, r[31:24]);
        3'd2: exe({6'h0E, r[7:0]}, r[31:24]);
        3'd3: exe({11'h00C, r[2:0]}, r[31:24]);
        3'd4: exe(r[23:10], r[31:24]);
        3'd5: rd(ra[r[2:0] % 6]);
        default: wr(7'h00, r[23:16]);
      endcase
    end
    instr_valid_i <= 1'b0;
    reg_we_i <= 1'b0;
    reg_re_i <= 1'b0;
    for (int i = 0; i < 10 && exp_q.size() > 0; i++) @(posedge clk_i);
    if (exp_q.size() > 0)
      miscompares++;
    end_of_test;
  end
endmodule // ssd_exec_tb

`default_nettype wire
